// File: logic/ddc_output_port_pins.sv
`include "ddc_port_defs.svh"

// How it works
// - Port A mode bit picks shared LSB role
// - Port B mode bit picks shared LSB role
// - Two-bit channel id shows current channel
// - IQ flag high for I, low Q
// - Low byte shared, high byte parallel only
// - Request output flags data available in parallel mode
// - Level indicator pair per converter input
// - Link mode: chanid MSB pin is ready input
// - Port clock: output if any port in link, input if both parallel
module ddc_output_port_pins #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  // Mode bits from the output control registers
  input wire logic porta_mode_parallel_in,
  input wire logic portb_mode_parallel_in,
  // Sample streams from the channel interleaver
  input wire logic [1:0] sample_valid_in,
  output logic [1:0] sample_ready_out,
  input wire logic [WIDTH-1:0] sample_data_a_in,
  input wire logic [WIDTH-1:0] sample_data_b_in,
  input wire logic [1:0] sample_chan_a_in,
  input wire logic [1:0] sample_chan_b_in,
  input wire logic [1:0] sample_iq_in,
  // Converter input samples for level indication
  input wire logic [WIDTH-1:0] adc_a_in,
  input wire logic [WIDTH-1:0] adc_b_in,
  // Port clock pin, two-way
  input wire logic pclk_in,
  output logic pclk_out,
  output logic pclk_oe_out,
  // Port A pins
  output logic [7:0] porta_low_data_out,
  output logic [7:0] porta_high_data_out,
  output logic porta_iq_flag_out,
  output logic porta_request_out,
  input wire logic porta_acknowledge_in,
  output logic porta_chanid_lsb_or_linkclk_out,
  input wire logic porta_chanid_msb_or_linkready_in,
  output logic porta_chanid_msb_or_linkready_out,
  output logic porta_chanid_msb_or_linkready_oe_out,
  // Port B pins
  output logic [7:0] portb_low_data_out,
  output logic [7:0] portb_high_data_out,
  output logic portb_iq_flag_out,
  output logic portb_request_out,
  input wire logic portb_acknowledge_in,
  output logic portb_chanid_lsb_or_linkclk_out,
  input wire logic portb_chanid_msb_or_linkready_in,
  output logic portb_chanid_msb_or_linkready_out,
  output logic portb_chanid_msb_or_linkready_oe_out,
  // Level indicator pairs
  output logic [1:0] level_ind_input_a_out,
  output logic [1:0] level_ind_input_b_out
);

  // Level code from magnitude; used for both inputs
  function automatic logic [1:0] level_code(input logic [WIDTH-1:0] s);
    logic [WIDTH-1:0] m;
    m = s[WIDTH-1] ? WIDTH'(~s + 1'b1) : s;
    if (m >= `LEVEL_HI_THRESH) level_code = 2'b11;
    else if (m >= `LEVEL_LO_THRESH) level_code = 2'b01;
    else level_code = 2'b00;
  endfunction

  // Pin synchronisers: pclk, two acks, two ready inputs
  logic [4:0] sync1_q, sync2_q, sync1_d, sync2_d;
  logic [4:0] prev_q, prev_d;
  logic pclk_rise;
  logic [1:0] ack_s, rdy_s;
  always_comb begin
    sync1_d = {portb_chanid_msb_or_linkready_in, porta_chanid_msb_or_linkready_in,
               portb_acknowledge_in, porta_acknowledge_in, pclk_in};
    sync2_d = sync1_q;
    prev_d = sync2_q;
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      prev_q <= 5'h00;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
    end
  end
  assign pclk_rise = sync2_q[0] & ~prev_q[0];
  assign ack_s = sync2_q[2:1];
  assign rdy_s = sync2_q[4:3];

  // Link clock divider, driven out only in link mode
  logic [3:0] div_q, div_d;
  logic lclk_q, lclk_d;
  logic lclk_fall;
  logic [1:0] mode_par;
  assign mode_par = {portb_mode_parallel_in, porta_mode_parallel_in};
  always_comb begin
    div_d = div_q + 4'h1;
    lclk_d = lclk_q;
    if (div_q == `LINK_HALF_DIV - 4'h1) begin
      div_d = 4'h0;
      lclk_d = ~lclk_q;
    end
  end
  assign lclk_fall = lclk_q & (div_q == `LINK_HALF_DIV - 4'h1);
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_q <= 4'h0;
      lclk_q <= 1'b0;
    end else begin
      div_q <= div_d;
      lclk_q <= lclk_d;
    end
  end

  // Per-port datapath; the two ports are identical
  logic [7:0] lo_q [2], lo_d [2], hi_q [2], hi_d [2];
  logic [1:0] chan_q [2], chan_d [2];
  logic [1:0] iq_q, iq_d, req_q, req_d, rdy_out_q, rdy_out_d, byte_q, byte_d;
  logic [WIDTH-1:0] word_q [2], word_d [2];
  ddc_port_pkg::port_state_e st_q [2], st_d [2];
  logic [WIDTH-1:0] in_data [2];
  logic [1:0] in_chan [2];
  assign in_data[0] = sample_data_a_in;
  assign in_data[1] = sample_data_b_in;
  assign in_chan[0] = sample_chan_a_in;
  assign in_chan[1] = sample_chan_b_in;

  for (genvar p = 0; p < 2; p++) begin : g_port
    always_comb begin
      st_d[p] = st_q[p];
      lo_d[p] = lo_q[p];
      hi_d[p] = hi_q[p];
      chan_d[p] = chan_q[p];
      word_d[p] = word_q[p];
      iq_d[p] = iq_q[p];
      req_d[p] = req_q[p];
      byte_d[p] = byte_q[p];
      rdy_out_d[p] = 1'b0;
      unique case (st_q[p])
        ddc_port_pkg::ST_IDLE: begin
          if (sample_valid_in[p] && !rdy_out_q[p]) begin
            rdy_out_d[p] = 1'b1;
            word_d[p] = in_data[p];
            chan_d[p] = in_chan[p];
            iq_d[p] = sample_iq_in[p];
            if (mode_par[p]) begin
              lo_d[p] = in_data[p][7:0];
              hi_d[p] = in_data[p][15:8];
              req_d[p] = 1'b1;
              st_d[p] = ddc_port_pkg::ST_REQ;
            end else begin
              hi_d[p] = 8'h00;
              byte_d[p] = 1'b0;
              st_d[p] = ddc_port_pkg::ST_LINK;
            end
          end
        end
        ddc_port_pkg::ST_REQ: begin
          if (pclk_rise && ack_s[p]) begin
            req_d[p] = 1'b0;
            st_d[p] = ddc_port_pkg::ST_IDLE;
          end
        end
        ddc_port_pkg::ST_LINK: begin
          if (lclk_fall && rdy_s[p]) begin
            lo_d[p] = byte_q[p] ? word_q[p][15:8] : word_q[p][7:0];
            byte_d[p] = ~byte_q[p];
            if (byte_q[p]) st_d[p] = ddc_port_pkg::ST_IDLE;
          end
        end
        default: st_d[p] = ddc_port_pkg::ST_IDLE;
      endcase
    end
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        st_q[p] <= ddc_port_pkg::ST_IDLE;
        lo_q[p] <= 8'h00;
        hi_q[p] <= 8'h00;
        chan_q[p] <= 2'h0;
        word_q[p] <= '0;
        iq_q[p] <= 1'b0;
        req_q[p] <= 1'b0;
        byte_q[p] <= 1'b0;
        rdy_out_q[p] <= 1'b0;
      end else begin
        st_q[p] <= st_d[p];
        lo_q[p] <= lo_d[p];
        hi_q[p] <= hi_d[p];
        chan_q[p] <= chan_d[p];
        word_q[p] <= word_d[p];
        iq_q[p] <= iq_d[p];
        req_q[p] <= req_d[p];
        byte_q[p] <= byte_d[p];
        rdy_out_q[p] <= rdy_out_d[p];
      end
    end
  end

  // Shared pins and level indicators, all registered
  logic [1:0] lsb_q, lsb_d, msb_oe_q, msb_oe_d, li_a_q, li_a_d, li_b_q, li_b_d;
  logic pclk_oe_q, pclk_oe_d;
  always_comb begin
    lsb_d[0] = porta_mode_parallel_in ? chan_d[0][0] : lclk_d;
    lsb_d[1] = portb_mode_parallel_in ? chan_d[1][0] : lclk_d;
    // MSB pin driven only in parallel
    msb_oe_d = mode_par;
    // pclk driven only when a port is link
    pclk_oe_d = ~(&mode_par);
    li_a_d = level_code(adc_a_in);
    li_b_d = level_code(adc_b_in);
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lsb_q <= 2'b00;
      msb_oe_q <= 2'b00;
      pclk_oe_q <= 1'b0;
      li_a_q <= 2'b00;
      li_b_q <= 2'b00;
    end else begin
      lsb_q <= lsb_d;
      msb_oe_q <= msb_oe_d;
      pclk_oe_q <= pclk_oe_d;
      li_a_q <= li_a_d;
      li_b_q <= li_b_d;
    end
  end

  assign sample_ready_out = rdy_out_q;
  assign pclk_out = lclk_q;
  assign pclk_oe_out = pclk_oe_q;
  assign porta_low_data_out = lo_q[0];
  assign porta_high_data_out = hi_q[0];
  assign porta_iq_flag_out = iq_q[0];
  assign porta_request_out = req_q[0];
  assign porta_chanid_lsb_or_linkclk_out = lsb_q[0];
  assign porta_chanid_msb_or_linkready_out = chan_q[0][1];
  assign porta_chanid_msb_or_linkready_oe_out = msb_oe_q[0];
  assign portb_low_data_out = lo_q[1];
  assign portb_high_data_out = hi_q[1];
  assign portb_iq_flag_out = iq_q[1];
  assign portb_request_out = req_q[1];
  assign portb_chanid_lsb_or_linkclk_out = lsb_q[1];
  assign portb_chanid_msb_or_linkready_out = chan_q[1][1];
  assign portb_chanid_msb_or_linkready_oe_out = msb_oe_q[1];
  assign level_ind_input_a_out = li_a_q;
  assign level_ind_input_b_out = li_b_q;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  req_hold_a: assert property (req_q[0] && !(pclk_rise && ack_s[0]) |=> req_q[0] && $stable(lo_q[0]))
    else $error("port A word moved before ack");
  req_drop_a: assert property (req_q[1] && pclk_rise && ack_s[1] |=> !req_q[1])
    else $error("port B request did not drop");
  lsb_mode_a: assert property (porta_mode_parallel_in && $stable(porta_mode_parallel_in) |=> lsb_q[0] == chan_q[0][0])
    else $error("port A lsb pin not channel id");
  lsb_link_a: assert property (!portb_mode_parallel_in |=> lsb_q[1] == lclk_q)
    else $error("port B lsb pin not link clock");
  msb_oe_a: assert property (1'b1 |=> msb_oe_q == $past(mode_par))
    else $error("msb pin enable wrong");
  pclk_oe_a: assert property (&mode_par |=> !pclk_oe_q)
    else $error("pclk driven in parallel mode");
  hi_link_a: assert property (st_q[0] == ddc_port_pkg::ST_LINK |-> hi_q[0] == 8'h00)
    else $error("high byte used in link mode");
  chan_hold_a: assert property (req_q[0] |=> $stable(chan_q[0]) && $stable(iq_q[0]) || !req_q[0])
    else $error("channel id changed during request");
  iq_take_a: assert property (st_q[0] == ddc_port_pkg::ST_IDLE && rdy_out_d[0] |=> iq_q[0] == $past(sample_iq_in[0]))
    else $error("iq flag not latched");
  level_a: assert property (li_a_q == level_code($past(adc_a_in)))
    else $error("level indicator wrong");
  par_xfer_c: cover property (req_q[0] ##[1:200] !req_q[0]);
  link_xfer_c: cover property (st_q[1] == ddc_port_pkg::ST_LINK ##[1:200] st_q[1] == ddc_port_pkg::ST_IDLE);
  level_hi_c: cover property (li_b_q == 2'b11);

endmodule

// File: logic/ddc_port_defs.svh
`ifndef DDC_PORT_DEFS_SVH
`define DDC_PORT_DEFS_SVH

// Port mode select bit position inside each port's output control byte
`define PORT_MODE_BIT 7
// Level indicator thresholds on the 16-bit sample magnitude
`define LEVEL_HI_THRESH 16'h6000
`define LEVEL_LO_THRESH 16'h1000
// Link clock divider: half period in system clocks
`define LINK_HALF_DIV 4'h4

`endif

// File: logic/ddc_port_pkg.sv
package ddc_port_pkg;
  // Per-port transfer state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_LINK = 2'b10
  } port_state_e;
endpackage

// File: test/rx_partner.sv
module rx_partner (
  // Request lines and link clocks from the block
  input wire logic [1:0] req_in,
  input wire logic [1:0] lclk_in,
  input wire logic pin_clk_in,
  // Handshake answers and own clock
  output logic [1:0] ack_out,
  output logic [1:0] ready_out,
  output logic clk_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'h1334;
  initial begin
    clk_out = 1'b0;
    forever #62.5 clk_out = ~clk_out;
  end
  // Quiet handshake lines before any traffic
  initial begin
    ack_out = 2'b00;
    ready_out = 2'b00;
  end
  for (genvar p = 0; p < 2; p++) begin : side_g
    // acknowledge each request; random late answers, one clock wide
    always @(negedge pin_clk_in) ack_out[p] <= req_in[p] && !ack_out[p] && ($random(seed) % 3 != 0);
    // ready moves after link clock rise, stalls at random
    always @(posedge lclk_in[p]) ready_out[p] <= ($random(seed) % 4 != 0);
  end
endmodule

// File: test/tb.sv
`include "ddc_port_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Signals named as the block's ports, so the instance binds them by name
  logic sys_clk_in, resetn_in, porta_mode_parallel_in, portb_mode_parallel_in, pclk_out, pclk_oe_out;
  logic porta_iq_flag_out, porta_request_out, porta_chanid_lsb_or_linkclk_out, porta_chanid_msb_or_linkready_out;
  logic porta_chanid_msb_or_linkready_oe_out, portb_iq_flag_out, portb_request_out, portb_chanid_lsb_or_linkclk_out;
  logic portb_chanid_msb_or_linkready_out, portb_chanid_msb_or_linkready_oe_out, part_clk;
  logic [1:0] sample_valid_in, sample_ready_out, sample_chan_a_in, sample_chan_b_in, sample_iq_in;
  logic [1:0] level_ind_input_a_out, level_ind_input_b_out, ack_w, rdy_w, rprev;
  logic [15:0] sample_data_a_in, sample_data_b_in, adc_a_in, adc_b_in, bv;
  logic [7:0] porta_low_data_out, porta_high_data_out, portb_low_data_out, portb_high_data_out;
  logic [18:0] qa[$], qb[$], held[2], e;
  logic [15:0] tbl [8] = '{16'h0000, 16'h0FFF, 16'h1000, 16'h5FFF, 16'h6000, 16'h7FFF, 16'hF000, 16'h8000};
  int err_total = 0, n_checks = 0, seed = 32'h1334;
  // Two-way pins resolved from the enables
  wire logic pclk_in = pclk_oe_out ? pclk_out : part_clk;
  wire logic porta_chanid_msb_or_linkready_in = porta_chanid_msb_or_linkready_oe_out ?
    porta_chanid_msb_or_linkready_out : rdy_w[0];
  wire logic portb_chanid_msb_or_linkready_in = portb_chanid_msb_or_linkready_oe_out ?
    portb_chanid_msb_or_linkready_out : rdy_w[1];
  wire logic porta_acknowledge_in = ack_w[0];
  wire logic portb_acknowledge_in = ack_w[1];
  wire logic [1:0] req_w = {portb_request_out, porta_request_out};
  wire logic [1:0] lclk_w = {portb_chanid_lsb_or_linkclk_out, porta_chanid_lsb_or_linkclk_out};
  wire logic [1:0] mode_w = {portb_mode_parallel_in, porta_mode_parallel_in};
  wire logic [18:0] seen_w [2];
  assign seen_w[0] = {porta_chanid_msb_or_linkready_out, porta_chanid_lsb_or_linkclk_out, porta_iq_flag_out,
    porta_high_data_out, porta_low_data_out};
  assign seen_w[1] = {portb_chanid_msb_or_linkready_out, portb_chanid_lsb_or_linkclk_out, portb_iq_flag_out,
    portb_high_data_out, portb_low_data_out};

  ddc_output_port_pins dut_u (.*);
  rx_partner part_u (.req_in(req_w), .lclk_in({portb_chanid_lsb_or_linkclk_out, porta_chanid_lsb_or_linkclk_out}),
    .pin_clk_in(pclk_in), .ack_out(ack_w), .ready_out(rdy_w), .clk_out(part_clk));

  // Clock at 200 MHz
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Level code from signed magnitude
  function automatic logic [1:0] lvl(input logic [15:0] v);
    logic [15:0] m;
    m = v[15] ? -v : v;
    return (m >= `LEVEL_HI_THRESH) ? 2'b11 : (m >= `LEVEL_LO_THRESH) ? 2'b01 : 2'b00;
  endfunction

  // Offer one random sample; expected word noted before the take to avoid racing the monitor
  task automatic send(input int p);
    logic [18:0] w;
    int n;
    w = $random(seed);
    n = 0;
    @(negedge sys_clk_in);
    if (p == 0) {sample_chan_a_in, sample_iq_in[0], sample_data_a_in} = w;
    else {sample_chan_b_in, sample_iq_in[1], sample_data_b_in} = w;
    if (p == 0) qa.push_back(w);
    else qb.push_back(w);
    sample_valid_in[p] = 1'b1;
    do @(negedge sys_clk_in); while (sample_ready_out[p] !== 1'b1 && ++n < 3000);
    sample_valid_in[p] = 1'b0;
    if (n >= 3000) begin
      err_total++;
      end_sim();
    end
  endtask

  // Bounded wait until every noted word is seen and no request is open; modes only change then
  task automatic drain;
    int n;
    n = 0;
    while ((qa.size() > 0 || qb.size() > 0 || req_w !== 2'b00) && n < 4000) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n >= 4000) begin
      err_total++;
      end_sim();
    end
  endtask

  // Bounded wait for a link clock rise on one port, so a new word is taken well before the next fall
  task automatic wait_rise(input int p);
    int n;
    n = 0;
    while (lclk_w[p] !== 1'b0 && n < 20) begin
      @(negedge sys_clk_in);
      n++;
    end
    while (lclk_w[p] !== 1'b1 && n < 40) begin
      @(negedge sys_clk_in);
      n++;
    end
    if (n >= 40) begin
      err_total++;
      end_sim();
    end
  endtask

  // Parallel words compared at request rise, held value again at its fall
  always @(negedge sys_clk_in) begin
    for (int p = 0; p < 2; p++) begin
      if (req_w[p] === 1'b1 && rprev[p] === 1'b0) begin
        e = (p == 0) ? qa.pop_front() : qb.pop_front();
        held[p] = e;
        check(seen_w[p], e);
      end
      if (req_w[p] === 1'b0 && rprev[p] === 1'b1) check(seen_w[p], held[p]);
    end
    rprev = req_w;
  end

  // Link bytes per port: low byte first, upper lines idle
  for (genvar p = 0; p < 2; p++) begin : link_g
    logic [18:0] le;
    int bidx = 0;
    always @(negedge lclk_w[p]) begin
      if (mode_w[p] === 1'b0 && rdy_w[p] === 1'b1 && ((p == 0) ? qa.size() : qb.size()) > 0) begin
        repeat (2) @(negedge sys_clk_in);
        le = (p == 0) ? qa[0] : qb[0];
        check({3'h0, seen_w[p][15:0]}, {11'h000, bidx ? le[15:8] : le[7:0]});
        if (bidx && p == 0) void'(qa.pop_front());
        if (bidx && p == 1) void'(qb.pop_front());
        bidx = !bidx;
      end
    end
  end

  // Hang guard
  initial begin
    repeat (90000) @(posedge sys_clk_in);
    err_total++;
    end_sim();
  end

  // Main sequence
  initial begin
    {resetn_in, sample_valid_in, sample_chan_a_in, sample_chan_b_in, sample_iq_in} = 9'h000;
    {sample_data_a_in, sample_data_b_in, adc_a_in, adc_b_in} = 64'h0;
    {porta_mode_parallel_in, portb_mode_parallel_in, rprev} = 4'hC;
    repeat (12) @(negedge sys_clk_in);
    resetn_in = 1'b1;
    repeat (2) @(negedge sys_clk_in);
    check({17'h0, pclk_oe_out, portb_chanid_msb_or_linkready_oe_out}, 19'h00001);
    fork
      repeat (10) send(0);
      repeat (10) send(1);
    join
    drain();
    // level codes at each threshold boundary
    foreach (tbl[i]) begin
      bv = $random(seed);
      @(negedge sys_clk_in);
      {adc_a_in, adc_b_in} = {tbl[i], bv};
      @(negedge sys_clk_in);
      check({15'h0, level_ind_input_a_out, level_ind_input_b_out}, {15'h0, lvl(tbl[i]), lvl(bv)});
    end
    portb_mode_parallel_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    check({17'h0, pclk_oe_out, portb_chanid_msb_or_linkready_oe_out}, 19'h00002);
    repeat (6) send(0);
    drain();
    repeat (8) begin
      drain();
      wait_rise(1);
      send(1);
    end
    drain();
    // Port A joins link mode as well
    porta_mode_parallel_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    check({16'h0, pclk_oe_out, porta_chanid_msb_or_linkready_oe_out,
      porta_chanid_lsb_or_linkclk_out ^ pclk_out}, 19'h00004);
    repeat (4) begin
      drain();
      wait_rise(0);
      send(0);
    end
    drain();
    end_sim();
  end
endmodule
